/* hdl/pcfg_bank.sv */
// Notes on behaviour
// - Delineator-off bit 0 delineates in cell processor, 1 in PLCP framer.
// - In SPI-3 mode without PLCP, bit 6 picks packet (0) or cell (1).
// - PLCP enabled in SPI-3 mode always forces cell processing.
// - Six-bit framing select in control bits 5 to 0.
// - Bit 13 picks receive gapped/low clock (0) or receive clock out (1).
// - Bit 12 picks receive data enable (0) or frame start out (1).
// - Bit 11 enables receive line and fractional pins.
// - Bit 10 picks transmit gapped/low clock (0) or clock out (1).
// - Bit 9 picks transmit data enable (0) or frame start out (1).
// - Bit 8 enables transmit line and fractional pins.
// - Bits 7:6 pick local 8 kHz source; usable as global reference.
// - Bit 5: 1 uses port 8 kHz source for PLCP, 0 global.
// - Loop timing clocks transmit from receive or adapter clock, ignores clock pin.
// - Rate adapter clock bit inverted: 0 uses adapter clocks, 1 does not.
// - Three timing selects: 0 output clocks, 1 input clocks.
// - Spare bit is read/write storage with no effect.
// - System bus loopback bit loops transmit bus to receive bus.
// - Three-bit loopback select picks terminal, line, payload or diagnostic.
// - Four-bit pin B alarm select, gated by global enable.
// - Four-bit pin A alarm select, gated by global enable.
// - Each transmit invert bit inverts its pin polarity.
// - Transmit invert bits 13 and 9:6 unused.
`timescale 1ns/1ps
`default_nettype none
module pcfg_bank
(
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [9:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic [31:0]                    prdata,
    // Mode context
    input  wire logic                      sysbus_spi3_mode,
    input  wire logic                      plcp_enabled,
    input  wire logic                      gp_pin_a_global_en,
    input  wire logic                      gp_pin_b_global_en,
    // Configuration outputs
    output pcfg_pkg::pcfg_clkpin_type      clkpin_cfg,
    output pcfg_pkg::pcfg_lbalarm_type     lbalarm_cfg,
    output pcfg_pkg::pcfg_txpol_type       txpol_cfg,
    output pcfg_pkg::pcfg_proc_type        proc_cfg,
    output logic                           gp_pin_a_drive_en,
    output logic                           gp_pin_b_drive_en
);
    import pcfg_pkg::*;

    logic [15:0]   ctrl;
    logic [15:0]   clkpin;
    logic [15:0]   lbalarm;
    logic [15:0]   txpol;
    pcfg_proc_type next_proc;

    // Word address match, shared by every register decode
    function automatic logic addr_is(input logic [9:0] a, input logic [9:0] target);
        addr_is = (a == target);
    endfunction : addr_is

    // Address decode
    wire access      = psel && penable;
    wire wr_en       = access && pwrite;
    wire hit_ctrl    = addr_is(paddr, PCFG_CTRL_ADDR);
    wire hit_clkpin  = addr_is(paddr, PCFG_CLKPIN_ADDR);
    wire hit_lbalarm = addr_is(paddr, PCFG_LBALARM_ADDR);
    wire hit_txpol   = addr_is(paddr, PCFG_TXPOL_ADDR);
    wire hit_any     = hit_ctrl || hit_clkpin || hit_lbalarm || hit_txpol;

    // Masked write data per register
    wire [15:0] wdat_ctrl    = pwdata[15:0] & PCFG_CTRL_MASK;
    wire [15:0] wdat_clkpin  = pwdata[15:0] & PCFG_CLKPIN_MASK;
    wire [15:0] wdat_lbalarm = pwdata[15:0] & PCFG_LBALARM_MASK;
    wire [15:0] wdat_txpol   = pwdata[15:0] & PCFG_TXPOL_MASK;

    // Read mux
    wire [15:0] rd_word = hit_ctrl    ? ctrl    :
                          hit_clkpin  ? clkpin  :
                          hit_lbalarm ? lbalarm :
                          hit_txpol   ? txpol   : 16'h0000;

    // Derived processing decisions
    wire delin_plcp  = ctrl[PCFG_DELIN_BIT];
    wire cell_sel    = ctrl[PCFG_CELLP_BIT];
    wire cell_proc   = !sysbus_spi3_mode ? 1'b1 :
                       plcp_enabled ? 1'b1 : cell_sel;
    wire loop_tx     = clkpin[PCFG_LOOP_TIMING_EN_BIT];
    wire adapter_use = !clkpin[PCFG_RATE_ADAPTER_CLK_OFF_BIT];

    always_comb
    begin
        next_proc.delin_in_plcp     = delin_plcp;
        next_proc.cell_processing   = cell_proc;
        next_proc.tx_from_loop_clk  = loop_tx;
        next_proc.tx_clk_pin_used   = !loop_tx;
        next_proc.rate_adapter_used = adapter_use;
        next_proc.framing_select    = ctrl[5:0];
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl    <= PCFG_CTRL_RST;
            clkpin  <= PCFG_CLKPIN_RST;
            lbalarm <= PCFG_LBALARM_RST;
            txpol   <= PCFG_TXPOL_RST;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl <= wdat_ctrl;
            if (hit_clkpin)
                clkpin <= wdat_clkpin;
            if (hit_lbalarm)
                lbalarm <= wdat_lbalarm;
            if (hit_txpol)
                txpol <= wdat_txpol;
        end
    end

    // Registered outputs and APB answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            prdata            <= 32'h0000_0000;
            clkpin_cfg        <= PCFG_CLKPIN_RST;
            lbalarm_cfg       <= PCFG_LBALARM_RST;
            txpol_cfg         <= PCFG_TXPOL_RST;
            proc_cfg          <= '0;
            gp_pin_a_drive_en <= 1'b0;
            gp_pin_b_drive_en <= 1'b0;
        end
        else
        begin
            pready            <= psel && !penable;
            pslverr           <= psel && !penable && !hit_any;
            prdata            <= {16'h0000, rd_word};
            clkpin_cfg        <= clkpin;
            lbalarm_cfg       <= lbalarm;
            txpol_cfg         <= txpol;
            proc_cfg          <= next_proc;
            gp_pin_a_drive_en <= gp_pin_a_global_en;
            gp_pin_b_drive_en <= gp_pin_b_global_en;
        end
    end

    // Assertions
    a_proc_forced_cell: assert property (@(posedge pclk) disable iff (!presetn)
        (sysbus_spi3_mode && plcp_enabled) |=> proc_cfg.cell_processing)
        else $error("cell processing not forced");
    a_proc_cell_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (sysbus_spi3_mode && !plcp_enabled) |=> proc_cfg.cell_processing == $past(cell_sel))
        else $error("cell select not followed");
    a_delin_follow: assert property (@(posedge pclk) disable iff (!presetn)
        proc_cfg.delin_in_plcp == $past(ctrl[7]))
        else $error("delineator choice wrong");
    a_frame_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ctrl) |=> ##1 proc_cfg.framing_select == $past(pwdata[5:0], 2))
        else $error("framing select wrong");
    a_loop_pin: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> proc_cfg.tx_clk_pin_used == !$past(clkpin[PCFG_LOOP_TIMING_EN_BIT]))
        else $error("loop timing pin use wrong");
    a_adapter_sense: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_clkpin) |=> ##1 proc_cfg.rate_adapter_used == !$past(pwdata[3], 2))
        else $error("adapter sense wrong");
    a_txpol_unused: assert property (@(posedge pclk) disable iff (!presetn)
        txpol_cfg.unused13 == 1'b0 && txpol_cfg.unused9_6 == 4'h0)
        else $error("unused invert bits set");
    a_clkpin_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_clkpin) |=> ##1 clkpin_cfg == ($past(pwdata[15:0], 2) & 16'h3fff))
        else $error("clock pin write lost");
    a_read_zero_hi: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_lbalarm) |=> prdata[14:12] == 3'h0)
        else $error("unused bits read nonzero");
    a_spare_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_lbalarm) |=> lbalarm[15] == $past(pwdata[15]))
        else $error("spare bit not stored");
    a_gpa_gate: assert property (@(posedge pclk) disable iff (!presetn)
        gp_pin_a_drive_en == $past(gp_pin_a_global_en))
        else $error("pin A gate wrong");

    // Bus steps shared by the checks below
    sequence s_setup;
        psel && !penable;
    endsequence : s_setup

    sequence s_ctrl_wr;
        wr_en && hit_ctrl;
    endsequence : s_ctrl_wr

    sequence s_clkpin_wr;
        wr_en && hit_clkpin;
    endsequence : s_clkpin_wr

    sequence s_lbalarm_wr;
        wr_en && hit_lbalarm;
    endsequence : s_lbalarm_wr

    sequence s_txpol_wr;
        wr_en && hit_txpol;
    endsequence : s_txpol_wr

    // Every setup cycle is answered in the next cycle, no wait states
    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready)
        else $error("no answer after setup");

    // The answer lasts one cycle, so no transfer is accepted twice
    a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("answer held too long");

    // Unmapped words are refused with an error
    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit_any) |=> pslverr)
        else $error("unmapped word not refused");

    // Mapped words never answer with an error
    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_any) |=> !pslverr)
        else $error("mapped word refused");

    // An error only ever comes with the answer
    a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without answer");

    // Upper half of the read word is always zero
    a_read_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");

    // Unused control bits never hold a one
    a_ctrl_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[15:8] == 8'h00)
        else $error("unused control bits set");

    // Unused clock-pin bits never reach the outputs
    a_clkpin_unused: assert property (@(posedge pclk) disable iff (!presetn)
        clkpin_cfg.unused == 2'b00)
        else $error("unused clock pin bits set");

    // Unused loopback bits never reach the outputs
    a_lbalarm_unused: assert property (@(posedge pclk) disable iff (!presetn)
        lbalarm_cfg.unused == 3'b000)
        else $error("unused loopback bits set");

    // A write to an unmapped word leaves the control, clock-pin and loopback registers alone
    a_unmapped_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && !hit_any) |=> $stable(ctrl) && $stable(clkpin) && $stable(lbalarm))
        else $error("unmapped write changed a register");

    // Control word reads back what is stored
    a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        (s_setup ##0 hit_ctrl) |=> prdata == {16'h0000, $past(ctrl)})
        else $error("control read wrong");

    // Polarity word reads back what is stored
    a_read_txpol: assert property (@(posedge pclk) disable iff (!presetn)
        (s_setup ##0 hit_txpol) |=> prdata == {16'h0000, $past(txpol)})
        else $error("polarity read wrong");

    // Receive clock pin function follows bit 13
    a_rx_clk_sel: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.rx_clk_out_sel == $past(pwdata[13], 2))
        else $error("receive clock select wrong");

    // Receive frame start pin function follows bit 12
    a_rx_sof_sel: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.rx_frame_start_out_sel == $past(pwdata[12], 2))
        else $error("receive frame start select wrong");

    // Receive line pins enable follows bit 11
    a_rx_pins_en: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.rx_line_frac_pins_en == $past(pwdata[11], 2))
        else $error("receive pin enable wrong");

    // Transmit clock pin function follows bit 10
    a_tx_clk_sel: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.tx_clk_out_sel == $past(pwdata[10], 2))
        else $error("transmit clock select wrong");

    // Transmit frame start pin function follows bit 9
    a_tx_sof_sel: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.tx_frame_start_out_sel == $past(pwdata[9], 2))
        else $error("transmit frame start select wrong");

    // Transmit line pins enable follows bit 8
    a_tx_pins_en: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.tx_line_frac_pins_en == $past(pwdata[8], 2))
        else $error("transmit pin enable wrong");

    // Local 8 kHz source follows bits 7 and 6
    a_local_ref_sel: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.local_8k_ref_sel == $past(pwdata[7:6], 2))
        else $error("local reference select wrong");

    // Trailer timing reference source follows bit 5
    a_plcp_ref_src: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg.plcp_8k_ref_src == $past(pwdata[5], 2))
        else $error("trailer reference source wrong");

    // Loop timing choice reaches the processing outputs
    a_loop_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 proc_cfg.tx_from_loop_clk == $past(pwdata[4], 2))
        else $error("loop timing not followed");

    // Three I/O timing selects follow bits 2 to 0
    a_timing_sel: assert property (@(posedge pclk) disable iff (!presetn)
        s_clkpin_wr |=> ##1 clkpin_cfg[2:0] == $past(pwdata[2:0], 2))
        else $error("timing select wrong");

    // Spare bit reaches the outputs unchanged
    a_spare_out: assert property (@(posedge pclk) disable iff (!presetn)
        s_lbalarm_wr |=> ##1 lbalarm_cfg.spare_cfg_bit == $past(pwdata[15], 2))
        else $error("spare bit output wrong");

    // System bus loopback follows bit 11
    a_sysbus_loop: assert property (@(posedge pclk) disable iff (!presetn)
        s_lbalarm_wr |=> ##1 lbalarm_cfg.sysbus_loopback_en == $past(pwdata[11], 2))
        else $error("system loopback wrong");

    // Loopback mode code follows bits 10 to 8
    a_loop_mode: assert property (@(posedge pclk) disable iff (!presetn)
        s_lbalarm_wr |=> ##1 lbalarm_cfg.loopback_select == $past(pwdata[10:8], 2))
        else $error("loopback mode wrong");

    // Pin B alarm code follows bits 7 to 4
    a_gpb_alarm: assert property (@(posedge pclk) disable iff (!presetn)
        s_lbalarm_wr |=> ##1 lbalarm_cfg.gp_pin_b_alarm_sel == $past(pwdata[7:4], 2))
        else $error("pin B alarm select wrong");

    // Pin A alarm code follows bits 3 to 0
    a_gpa_alarm: assert property (@(posedge pclk) disable iff (!presetn)
        s_lbalarm_wr |=> ##1 lbalarm_cfg.gp_pin_a_alarm_sel == $past(pwdata[3:0], 2))
        else $error("pin A alarm select wrong");

    // Pin B drive is gated by the global enable
    a_gpb_gate: assert property (@(posedge pclk) disable iff (!presetn)
        gp_pin_b_drive_en == $past(gp_pin_b_global_en))
        else $error("pin B gate wrong");

    // Polarity word keeps the implemented bits only
    a_txpol_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_txpol_wr |=> ##1 txpol_cfg == ($past(pwdata[15:0], 2) & PCFG_TXPOL_MASK))
        else $error("polarity write lost");

    // Outside the packet bus mode the cell choice has no effect
    a_cell_outside: assert property (@(posedge pclk) disable iff (!presetn)
        !sysbus_spi3_mode |=> proc_cfg.cell_processing)
        else $error("cell choice leaked outside mode");

    // A zero cell choice selects packets when nothing forces cells
    a_packet_pick: assert property (@(posedge pclk) disable iff (!presetn)
        (sysbus_spi3_mode && !plcp_enabled && !cell_sel) |=> !proc_cfg.cell_processing)
        else $error("packet processing not chosen");

    // Delineator choice reaches the processing outputs after a write
    a_delin_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_wr |=> ##1 proc_cfg.delin_in_plcp == $past(pwdata[7], 2))
        else $error("delineator write lost");

endmodule : pcfg_bank
`default_nettype wire

/* hdl/pcfg_pkg.sv */
package pcfg_pkg;

    // Register word indices; the APB byte address is four times the index
    localparam logic [7:0] PCFG_CTRL_IDX      = 8'h42;
    localparam logic [7:0] PCFG_CLKPIN_IDX    = 8'h44;
    localparam logic [7:0] PCFG_LBALARM_IDX   = 8'h46;
    localparam logic [7:0] PCFG_TXPOL_IDX     = 8'h4a;
    localparam logic [9:0] PCFG_CTRL_ADDR     = {PCFG_CTRL_IDX, 2'b00};
    localparam logic [9:0] PCFG_CLKPIN_ADDR   = {PCFG_CLKPIN_IDX, 2'b00};
    localparam logic [9:0] PCFG_LBALARM_ADDR  = {PCFG_LBALARM_IDX, 2'b00};
    localparam logic [9:0] PCFG_TXPOL_ADDR    = {PCFG_TXPOL_IDX, 2'b00};

    // Writable bit masks
    localparam logic [15:0] PCFG_CTRL_MASK    = 16'h00ff;
    localparam logic [15:0] PCFG_CLKPIN_MASK  = 16'h3fff;
    localparam logic [15:0] PCFG_LBALARM_MASK = 16'h8fff;
    localparam logic [15:0] PCFG_TXPOL_MASK   = 16'hdc3f;

    // Reset values
    localparam logic [15:0] PCFG_CTRL_RST     = 16'h0000;
    localparam logic [15:0] PCFG_CLKPIN_RST   = 16'h0000;
    localparam logic [15:0] PCFG_LBALARM_RST  = 16'h0000;
    localparam logic [15:0] PCFG_TXPOL_RST    = 16'h0000;

    // Field positions
    localparam int PCFG_DELIN_BIT  = 7;
    localparam int PCFG_CELLP_BIT  = 6;
    localparam int PCFG_LOOP_TIMING_EN_BIT  = 4;
    localparam int PCFG_RATE_ADAPTER_CLK_OFF_BIT  = 3;
    localparam int PCFG_SLB_BIT    = 11;

    // Clock-pin control word
    typedef struct packed {
        logic [1:0] unused;
        logic       rx_clk_out_sel;
        logic       rx_frame_start_out_sel;
        logic       rx_line_frac_pins_en;
        logic       tx_clk_out_sel;
        logic       tx_frame_start_out_sel;
        logic       tx_line_frac_pins_en;
        logic [1:0] local_8k_ref_sel;
        logic       plcp_8k_ref_src;
        logic       loop_timing_en;
        logic       rate_adapter_clk_off;
        logic       rx_framer_io_timing_sel;
        logic       tx_framer_io_timing_sel;
        logic       tx_line_io_timing_sel;
    } pcfg_clkpin_type;

    // Loopback and alarm output word
    typedef struct packed {
        logic       spare_cfg_bit;
        logic [2:0] unused;
        logic       sysbus_loopback_en;
        logic [2:0] loopback_select;
        logic [3:0] gp_pin_b_alarm_sel;
        logic [3:0] gp_pin_a_alarm_sel;
    } pcfg_lbalarm_type;

    // Transmit polarity word
    typedef struct packed {
        logic       inv_tx_payload_en_out;
        logic       inv_tx_payload_data;
        logic       unused13;
        logic       inv_tx_frame_start_out;
        logic       inv_tx_overhead_en_in;
        logic       inv_tx_overhead_serial;
        logic [3:0] unused9_6;
        logic       inv_tx_frame_start_in;
        logic       inv_tx_neg_line;
        logic       inv_tx_pos_line;
        logic       inv_tx_line_clk;
        logic       inv_tx_clk_out;
        logic       inv_tx_clk_in;
    } pcfg_txpol_type;

    // Derived processing choices
    typedef struct packed {
        logic       delin_in_plcp;
        logic       cell_processing;
        logic       tx_from_loop_clk;
        logic       tx_clk_pin_used;
        logic       rate_adapter_used;
        logic [5:0] framing_select;
    } pcfg_proc_type;

endpackage : pcfg_pkg

/* testbench/pcfg_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pcfg_bank_bench;
    import pcfg_pkg::*;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [9:0]       paddr = 10'h000;
    logic [31:0]      pwdata = 32'h0;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             spi3 = 1'b0;
    logic             plcp = 1'b0;
    logic             gpa = 1'b0;
    logic             gpb = 1'b0;
    pcfg_clkpin_type  clkpin_cfg;
    pcfg_lbalarm_type lbalarm_cfg;
    pcfg_txpol_type   txpol_cfg;
    pcfg_proc_type    proc_cfg;
    logic             gpa_en;
    logic             gpb_en;
    logic [31:0]      rd;
    logic             er;
    int               err_count = 0;
    int               checks_done = 0;
    int               cycles = 0;
    logic [9:0]       addrs [4] = '{PCFG_CTRL_ADDR, PCFG_CLKPIN_ADDR, PCFG_LBALARM_ADDR,
                                    PCFG_TXPOL_ADDR};
    logic [15:0]      masks [4] = '{PCFG_CTRL_MASK, PCFG_CLKPIN_MASK, PCFG_LBALARM_MASK,
                                    PCFG_TXPOL_MASK};

    pcfg_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .sysbus_spi3_mode(spi3), .plcp_enabled(plcp),
        .gp_pin_a_global_en(gpa), .gp_pin_b_global_en(gpb), .clkpin_cfg(clkpin_cfg),
        .lbalarm_cfg(lbalarm_cfg), .txpol_cfg(txpol_cfg), .proc_cfg(proc_cfg),
        .gp_pin_a_drive_en(gpa_en), .gp_pin_b_drive_en(gpb_en));

    // Clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    // Every register zero after reset, and clock-pin, loopback and polarity outputs idle
    task automatic t_reset();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, addrs[i], 32'h0);
            check("reset read", rd, 32'h0);
        end
        check("reset clkpin", {16'h0, clkpin_cfg}, 32'h0);
        check("reset lbalarm", {16'h0, lbalarm_cfg}, 32'h0);
        check("reset txpol", {16'h0, txpol_cfg}, 32'h0);
    endtask : t_reset

    // Patterns through every register, unused bits dropped
    task automatic t_rw(input logic [31:0] pat);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, addrs[i], pat);
            apb(1'b0, addrs[i], 32'h0);
            check("readback", rd, {16'h0, pat[15:0] & masks[i]});
            check("pslverr", {31'h0, er}, 32'h0);
        end
        settle();
        check("framing", {26'h0, proc_cfg.framing_select}, {26'h0, pat[5:0]});
        check("clkpin", {16'h0, clkpin_cfg}, {16'h0, pat[15:0] & 16'h3fff});
        check("lbalarm", {16'h0, lbalarm_cfg}, {16'h0, pat[15:0] & 16'h8fff});
        check("txpol", {16'h0, txpol_cfg}, {16'h0, pat[15:0] & 16'hdc3f});
    endtask : t_rw

    // Unmapped place refused
    task automatic t_unmapped();
        apb(1'b1, 10'h140, 32'hffff_ffff);
        check("unmapped wr err", {31'h0, er}, 32'h1);
        apb(1'b0, 10'h140, 32'h0);
        check("unmapped rd", {er, rd[30:0]}, 32'h8000_0000);
    endtask : t_unmapped

    // Delineation, cell/packet choice, loop timing and adapter clock selects
    task automatic t_proc();
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = 3'(i);
            spi3 <= m[0];
            plcp <= m[1];
            apb(1'b1, PCFG_CTRL_ADDR, {24'h0, m[1] ^ m[2], m[2], 6'h15});
            apb(1'b1, PCFG_CLKPIN_ADDR, {27'h0, m[0], m[2], 3'h0});
            settle();
            check("delin", {31'h0, proc_cfg.delin_in_plcp}, {31'h0, m[1] ^ m[2]});
            check("cellp", {31'h0, proc_cfg.cell_processing},
                {31'h0, (m[0] & ~m[1]) ? m[2] : 1'b1});
            check("looptx", {30'h0, proc_cfg.tx_from_loop_clk, proc_cfg.tx_clk_pin_used},
                {30'h0, m[0], ~m[0]});
            check("adapter", {31'h0, proc_cfg.rate_adapter_used}, {31'h0, ~m[2]});
        end
    endtask : t_proc

    // General-purpose pin drive follows the global enables
    task automatic t_gp();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            gpa <= i[0];
            gpb <= i[1];
            settle();
            check("gp drive", {30'h0, gpb_en, gpa_en}, 32'(i));
        end
    endtask : t_gp

    task automatic stop_test();
        if (err_count == 0 && checks_done > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rw(32'hffff_ffff);
        t_rw(32'h1234_a5a5);
        t_rw(32'h0000_5a5a);
        t_unmapped();
        t_proc();
        t_gp();
        stop_test();
    end
endmodule : pcfg_bank_bench
`default_nettype wire
